/* hdl/afrm_pkg.sv */
package afrm_pkg;
  localparam int          AFRM_AXES       = 4;
  localparam int          AFRM_MASK_W     = 48;
  localparam int          AFRM_AUX_SEL_W  = 4;
  localparam int          AFRM_AUX_OUTS   = 16;
  localparam logic [47:0] AFRM_GDET_RST   = 48'hFFFF_FFFF_319F;
  localparam logic [47:0] AFRM_DIS_RST    = 48'hFFFF_FFF0_EF87;
  localparam logic [47:0] AFRM_IRQ_RST    = 48'hFFFF_FFF0_0000;
  localparam logic [47:0] AFRM_AUX_RST    = 48'hFFFF_FFF0_0000;
  localparam logic [47:0] AFRM_HALT_RST   = 48'hFFFF_FFF0_8E00;
  localparam logic [47:0] AFRM_ABORT_RST  = 48'hFFFF_FFFF_9E78;
  localparam logic [47:0] AFRM_BRAKE_RST  = 48'hFFFF_FFF0_0000;
  localparam int          AFRM_BIT_POSERR = 0;
  localparam int          AFRM_BIT_ESTOP  = 14;
  localparam int          AFRM_BIT_LINK0  = 16;
  localparam int          AFRM_BIT_CABLE  = 31;
  typedef enum logic [1:0] {
    AFRM_RUN   = 2'b00,
    AFRM_RAMP  = 2'b01,
    AFRM_WAIT  = 2'b10
  } afrm_abort_t;
endpackage : afrm_pkg

/* hdl/afrm_unit.sv */
`timescale 1ns/1ps
// Overview of operation
// - global mask gates every fault for all mask responses; estop disable bypasses it
// - global mask resets to FFFF FFFF 319F
// - each axis uses its own mask set
// - disable mask faults disable that axis
// - disable mask resets to FFFF FFF0 EF87
// - interrupt mask faults raise host interrupt
// - interrupt is OR of selected faults
// - interrupt mask resets to FFFF FFF0 0000
// - aux mask faults drive selected output low
// - aux mask resets to FFFF FFF0 0000
// - halt mask faults stop queue fetching
// - halt mask resets to FFFF FFF0 8E00
// - halt forces velocity zero, stops contour
// - abort mask ramps axis, waits for acknowledge
// - abort decelerates each axis at own rate
// - abort mask resets to FFFF FFFF 9E78
// - brake mask faults engage brake; resets to FFFF FFF0 0000
// - brake follows axis enable state
// - fixed fault bit position encoding
// - bits 16..19 mirror any fault per axis
// - estop enabled by any mask, disables all
module afrm_unit
  import afrm_pkg::*;
(
  input  wire logic                                 i_clk,
  input  wire logic                                 i_rst_n,
  input  wire logic                                 i_ce,
  input  wire logic                                 i_tick,
  input  wire logic                                 i_reinit,
  input  wire logic [AFRM_AXES-1:0][AFRM_MASK_W-1:0] i_raw_fault,
  input  wire logic                                 i_estop_in,
  input  wire logic                                 i_fault_acknowledge,
  input  wire logic [AFRM_AXES-1:0]                 i_axis_enable_req,
  input  wire logic [AFRM_AXES-1:0]                 i_axis_stopped,
  input  wire logic                                 i_mask_we,
  input  wire logic [1:0]                           i_mask_axis,
  input  wire logic [2:0]                           i_mask_sel,
  input  wire logic [AFRM_MASK_W-1:0]               i_mask_wdata,
  input  wire logic [AFRM_AUX_SEL_W-1:0]            i_aux_out_bit_select,
  output logic [AFRM_AXES-1:0]                      o_axis_enabled,
  output logic                                      o_host_irq,
  output logic [AFRM_AUX_OUTS-1:0]                  o_aux_out,
  output logic                                      o_queue_halt,
  output logic                                      o_velocity_zero,
  output logic [AFRM_AXES-1:0]                      o_ramp_stop,
  output logic [AFRM_AXES-1:0]                      o_abort_wait,
  output logic [AFRM_AXES-1:0]                      o_brake,
  output logic                                      o_estop_active
);
  localparam logic [2:0] SEL_GDET  = 3'h0;
  localparam logic [2:0] SEL_DIS   = 3'h1;
  localparam logic [2:0] SEL_IRQ   = 3'h2;
  localparam logic [2:0] SEL_AUX   = 3'h3;
  localparam logic [2:0] SEL_HALT  = 3'h4;
  localparam logic [2:0] SEL_ABORT = 3'h5;
  localparam logic [2:0] SEL_BRAKE = 3'h6;

  logic       rst_sync1;
  logic       rst_sync;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync1 <= 1'b0;
      rst_sync  <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync  <= rst_sync1;
    end
  end
  assign rst_n = rst_sync;

  logic [AFRM_AXES-1:0][AFRM_MASK_W-1:0] global_detect_mask;
  logic [AFRM_AXES-1:0][AFRM_MASK_W-1:0] axis_disable_mask;
  logic [AFRM_AXES-1:0][AFRM_MASK_W-1:0] host_interrupt_mask;
  logic [AFRM_AXES-1:0][AFRM_MASK_W-1:0] aux_out_mask;
  logic [AFRM_AXES-1:0][AFRM_MASK_W-1:0] queue_halt_mask;
  logic [AFRM_AXES-1:0][AFRM_MASK_W-1:0] motion_abort_mask;
  logic [AFRM_AXES-1:0][AFRM_MASK_W-1:0] brake_engage_mask;

  logic [AFRM_AXES-1:0] any_fault;
  logic [AFRM_AXES-1:0] req_dis;
  logic [AFRM_AXES-1:0] req_irq;
  logic [AFRM_AXES-1:0] req_aux;
  logic [AFRM_AXES-1:0] req_halt;
  logic [AFRM_AXES-1:0] req_abort;
  logic [AFRM_AXES-1:0] req_brake;
  logic [AFRM_AXES-1:0] estop_use;
  logic                 estop_enabled;
  logic                 estop_latched;
  logic [AFRM_AXES-1:0] axis_fault_dis;
  afrm_abort_t          abort_st [AFRM_AXES];

  // linkage bits come from raw faults only so axes cannot loop on each other
  genvar ax;
  generate
    for (ax = 0; ax < AFRM_AXES; ax++) begin : g_axis
      logic [AFRM_MASK_W-1:0] fault_vec;
      logic [AFRM_MASK_W-1:0] detected;
      logic [AFRM_MASK_W-1:0] raw_clean;

      always_comb begin
        raw_clean = i_raw_fault[ax];
        raw_clean[AFRM_BIT_ESTOP] = 1'b0;
        raw_clean[AFRM_BIT_LINK0 +: AFRM_AXES] = '0;
      end
      assign any_fault[ax] = |(raw_clean & global_detect_mask[ax]);
      always_comb begin
        fault_vec = i_raw_fault[ax];
        fault_vec[AFRM_BIT_ESTOP] = i_estop_in & estop_enabled;
        fault_vec[AFRM_BIT_LINK0 +: AFRM_AXES] = any_fault;
      end
      assign detected       = fault_vec & global_detect_mask[ax];
      assign req_dis[ax]    = |(detected & axis_disable_mask[ax]);
      assign req_irq[ax]    = |(detected & host_interrupt_mask[ax]);
      assign req_aux[ax]    = |(detected & aux_out_mask[ax]);
      assign req_halt[ax]   = |(detected & queue_halt_mask[ax]);
      assign req_abort[ax]  = |(detected & motion_abort_mask[ax]);
      assign req_brake[ax]  = |(detected & brake_engage_mask[ax]);
      assign estop_use[ax]  = axis_disable_mask[ax][AFRM_BIT_ESTOP]
                            | host_interrupt_mask[ax][AFRM_BIT_ESTOP]
                            | aux_out_mask[ax][AFRM_BIT_ESTOP]
                            | queue_halt_mask[ax][AFRM_BIT_ESTOP]
                            | motion_abort_mask[ax][AFRM_BIT_ESTOP]
                            | brake_engage_mask[ax][AFRM_BIT_ESTOP]
                            | global_detect_mask[ax][AFRM_BIT_ESTOP];

      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          global_detect_mask[ax]  <= AFRM_GDET_RST;
          axis_disable_mask[ax]   <= AFRM_DIS_RST;
          host_interrupt_mask[ax] <= AFRM_IRQ_RST;
          aux_out_mask[ax]        <= AFRM_AUX_RST;
          queue_halt_mask[ax]     <= AFRM_HALT_RST;
          motion_abort_mask[ax]   <= AFRM_ABORT_RST;
          brake_engage_mask[ax]   <= AFRM_BRAKE_RST;
        end else if (i_ce) begin
          if (i_reinit) begin
            global_detect_mask[ax]  <= AFRM_GDET_RST;
            axis_disable_mask[ax]   <= AFRM_DIS_RST;
            host_interrupt_mask[ax] <= AFRM_IRQ_RST;
            aux_out_mask[ax]        <= AFRM_AUX_RST;
            queue_halt_mask[ax]     <= AFRM_HALT_RST;
            motion_abort_mask[ax]   <= AFRM_ABORT_RST;
            brake_engage_mask[ax]   <= AFRM_BRAKE_RST;
          end else if (i_mask_we && i_mask_axis == 2'(ax)) begin
            unique case (i_mask_sel)
              SEL_GDET:  global_detect_mask[ax]  <= i_mask_wdata;
              SEL_DIS:   axis_disable_mask[ax]   <= i_mask_wdata;
              SEL_IRQ:   host_interrupt_mask[ax] <= i_mask_wdata;
              SEL_AUX:   aux_out_mask[ax]        <= i_mask_wdata;
              SEL_HALT:  queue_halt_mask[ax]     <= i_mask_wdata;
              SEL_ABORT: motion_abort_mask[ax]   <= i_mask_wdata;
              SEL_BRAKE: brake_engage_mask[ax]   <= i_mask_wdata;
              default:   global_detect_mask[ax]  <= global_detect_mask[ax];
            endcase
          end
        end
      end

      // a disabling fault is latched until acknowledged; set wins over ack
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          axis_fault_dis[ax] <= 1'b0;
        end else if (i_ce && i_tick) begin
          if (req_dis[ax]) begin
            axis_fault_dis[ax] <= 1'b1;
          end else if (i_fault_acknowledge) begin
            axis_fault_dis[ax] <= 1'b0;
          end
        end
      end

      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          o_axis_enabled[ax] <= 1'b0;
          o_brake[ax]        <= 1'b1;
        end else if (i_ce && i_tick) begin
          o_axis_enabled[ax] <= i_axis_enable_req[ax] & ~req_dis[ax] & ~axis_fault_dis[ax]
                              & ~estop_latched & ~(i_estop_in & estop_enabled);
          o_brake[ax]        <= req_brake[ax] | req_dis[ax] | axis_fault_dis[ax]
                              | ~i_axis_enable_req[ax] | estop_latched
                              | (i_estop_in & estop_enabled);
        end
      end

      // ramp uses the axis own decel rate in the trajectory logic
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          abort_st[ax] <= AFRM_RUN;
        end else if (i_ce && i_tick) begin
          unique case (abort_st[ax])
            AFRM_RUN:  if (req_abort[ax]) abort_st[ax] <= AFRM_RAMP;
            AFRM_RAMP: if (i_axis_stopped[ax]) abort_st[ax] <= AFRM_WAIT;
            AFRM_WAIT: if (i_fault_acknowledge && !req_abort[ax]) abort_st[ax] <= AFRM_RUN;
            default:   abort_st[ax] <= AFRM_RUN;
          endcase
        end
      end

      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          o_ramp_stop[ax]  <= 1'b0;
          o_abort_wait[ax] <= 1'b0;
        end else if (i_ce) begin
          o_ramp_stop[ax]  <= (abort_st[ax] == AFRM_RAMP);
          o_abort_wait[ax] <= (abort_st[ax] != AFRM_RUN);
        end
      end
    end
  endgenerate

  assign estop_enabled = |estop_use;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      estop_latched <= 1'b0;
    end else if (i_ce && i_tick) begin
      if (i_estop_in && estop_enabled) begin
        estop_latched <= 1'b1;
      end else if (i_fault_acknowledge) begin
        estop_latched <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_estop_active <= 1'b0;
    end else if (i_ce) begin
      o_estop_active <= estop_latched;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_host_irq <= 1'b0;
    end else if (i_ce && i_tick) begin
      o_host_irq <= |req_irq;
    end
  end

  // aux outputs idle high; only the selected bit is pulled low
  logic [AFRM_AUX_OUTS-1:0] next_aux;
  always_comb begin
    next_aux = '1;
    next_aux[i_aux_out_bit_select] = ~(|req_aux);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_aux_out <= '1;
    end else if (i_ce && i_tick) begin
      o_aux_out <= next_aux;
    end
  end

  // halt holds until acknowledge with no halting fault present
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_queue_halt    <= 1'b0;
      o_velocity_zero <= 1'b0;
    end else if (i_ce && i_tick) begin
      if (|req_halt) begin
        o_queue_halt    <= 1'b1;
        o_velocity_zero <= 1'b1;
      end else if (i_fault_acknowledge) begin
        o_queue_halt    <= 1'b0;
        o_velocity_zero <= 1'b0;
      end
    end
  end

  a_halt_zero_vel: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_queue_halt == o_velocity_zero) else $error("halt without zero velocity");
  a_halt_sets: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick && |req_halt) |=> o_queue_halt) else $error("halt missed");
  a_irq_or: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick) |=> (o_host_irq == ($past(req_irq) != '0))) else $error("irq wrong");
  a_dis_axis0: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick && req_dis[0]) |=> !o_axis_enabled[0]) else $error("no disable");
  a_brake_dis: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick) ##1 !o_axis_enabled[0] |-> o_brake[0]) else $error("brake off");
  a_estop_all: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_estop_active |-> o_axis_enabled == '0) else $error("estop axis on");
  a_aux_low: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick && |req_aux) |=> !o_aux_out[$past(i_aux_out_bit_select)])
    else $error("aux not low");
  a_abort_wait: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick && req_abort[0] && abort_st[0] == AFRM_RUN) |=> ##1 o_abort_wait[0])
    else $error("abort missed");
  a_reinit_gdet: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_reinit) |=> global_detect_mask[0] == AFRM_GDET_RST)
    else $error("gdet default");

  // no estop in play: each axis answers to its own disable request only
  a_axis_own_mask: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick && !i_estop_in && !estop_latched)
    |=> o_axis_enabled == ($past(i_axis_enable_req) & ~$past(req_dis) & ~$past(axis_fault_dis)))
    else $error("axis enable wrong");
  a_gdet_gate: assert property (@(posedge i_clk) disable iff (!rst_n)
    (global_detect_mask[1] == '0) |-> !(req_dis[1] || req_irq[1] || req_abort[1]))
    else $error("masked fault acted");
  a_link_axis: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick && any_fault[1] && axis_disable_mask[0][AFRM_BIT_LINK0 + 1]
     && global_detect_mask[0][AFRM_BIT_LINK0 + 1]) |=> !o_axis_enabled[0])
    else $error("linkage ignored");
  a_brake_fault: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick && req_brake[0]) |=> o_brake[0]) else $error("brake not engaged");
  a_brake_release: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick) ##1 o_axis_enabled[0] |-> o_brake[0] == $past(req_brake[0]))
    else $error("brake held while enabled");
  a_estop_latch: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_tick && i_estop_in && estop_enabled) |=> estop_latched)
    else $error("estop not latched");
  a_ramp_out: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && abort_st[1] == AFRM_RAMP) |=> o_ramp_stop[1]) else $error("ramp not shown");
  a_reinit_dis: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_reinit) |=> axis_disable_mask[1] == AFRM_DIS_RST)
    else $error("disable default");
  a_reinit_irq: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_reinit) |=> host_interrupt_mask[2] == AFRM_IRQ_RST)
    else $error("irq default");
  a_reinit_aux: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_reinit) |=> aux_out_mask[3] == AFRM_AUX_RST)
    else $error("aux default");
  a_reinit_halt: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_reinit) |=> queue_halt_mask[0] == AFRM_HALT_RST)
    else $error("halt default");
  a_reinit_abort: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_reinit) |=> motion_abort_mask[1] == AFRM_ABORT_RST)
    else $error("abort default");
  a_reinit_brake: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_reinit) |=> brake_engage_mask[2] == AFRM_BRAKE_RST)
    else $error("brake default");

  c_halt: cover property (@(posedge i_clk) disable iff (!rst_n) $rose(o_queue_halt));
  c_ramp3: cover property (@(posedge i_clk) disable iff (!rst_n) $rose(o_ramp_stop[3]));
  c_irq: cover property (@(posedge i_clk) disable iff (!rst_n) $rose(o_host_irq));
  c_abort: cover property (@(posedge i_clk) disable iff (!rst_n) $fell(o_abort_wait[0]));
  c_estop: cover property (@(posedge i_clk) disable iff (!rst_n) $fell(o_estop_active));
endmodule : afrm_unit

/* tb/afrm_traj_model.sv */
`timescale 1ns/1ps
module afrm_traj_model
  import afrm_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_slow,
  input  wire logic [AFRM_AXES-1:0] i_ramp_stop,
  output logic      [AFRM_AXES-1:0] o_axis_stopped
);
  logic [3:0] cnt [AFRM_AXES];
  // each axis ramps at its own rate; slow stretches every ramp
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt            <= '{default: 4'h0};
      o_axis_stopped <= '0;
    end else begin
      for (int k = 0; k < AFRM_AXES; k++) begin
        if (!i_ramp_stop[k]) begin
          cnt[k]            <= 4'h0;
          o_axis_stopped[k] <= 1'b0;
        end else if (cnt[k] == 4'(2 + k + (i_slow ? 4 : 0))) begin
          o_axis_stopped[k] <= 1'b1;
        end else begin
          cnt[k] <= cnt[k] + 4'h1;
        end
      end
    end
  end
endmodule : afrm_traj_model

/* tb/axis_fault_response_masks_bench.sv */
`timescale 1ns/1ps
module axis_fault_response_masks_bench
  import afrm_pkg::*;
;
  logic              clk, rst_n, ce, tick, rein, estop, ack, we, slow;
  logic [3:0][47:0]  rw, fq;
  logic [3:0]        req, stp, asel, en, rs, aw, brk;
  logic [1:0]        ma;
  logic [2:0]        ms;
  logic [47:0]       md;
  logic [15:0]       aux;
  logic              irq, halt, vz, ea;
  logic [47:0]       m [4][7];
  int                bad_count, n_tests;

  afrm_unit afrm_unit_i (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_tick(tick),
    .i_reinit(rein), .i_raw_fault(rw), .i_estop_in(estop), .i_fault_acknowledge(ack),
    .i_axis_enable_req(req), .i_axis_stopped(stp), .i_mask_we(we), .i_mask_axis(ma),
    .i_mask_sel(ms), .i_mask_wdata(md), .i_aux_out_bit_select(asel),
    .o_axis_enabled(en), .o_host_irq(irq), .o_aux_out(aux), .o_queue_halt(halt),
    .o_velocity_zero(vz), .o_ramp_stop(rs), .o_abort_wait(aw), .o_brake(brk),
    .o_estop_active(ea));
  afrm_traj_model afrm_traj_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
    .i_ramp_stop(rs), .o_axis_stopped(stp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (exp !== got) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic void mdef();
    for (int j = 0; j < 4; j++) begin
      m[j] = '{AFRM_GDET_RST, AFRM_DIS_RST, AFRM_IRQ_RST, AFRM_AUX_RST,
               AFRM_HALT_RST, AFRM_ABORT_RST, AFRM_BRAKE_RST};
    end
  endfunction : mdef

  // bit 14 and linkage bits are never taken from the raw inputs
  function automatic logic resp(int j, int s);
    logic [47:0] e;
    e = rw[j] & 48'hFFFF_FFF0_BFFF;
    for (int k = 0; k < 4; k++) begin
      e[16+k] = |(rw[k] & m[k][0] & 48'hFFFF_FFF0_BFFF);
    end
    return |(e & m[j][0] & m[j][s]);
  endfunction : resp

  task automatic wr(input logic [1:0] a, input logic [2:0] s, input logic [47:0] d);
    ma = a;
    ms = s;
    md = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    if (s != 7) m[a][s] = d;
  endtask : wr

  // settle enables first: brake may follow the previous enable state
  task automatic apply();
    logic       ir, ax, hl;
    logic [3:0] ds, ab, bk;
    tick = 1'b1;
    repeat (3) @(negedge clk);
    rw = fq;
    fq = '0;
    {ir, ax, hl} = 3'h0;
    for (int j = 0; j < 4; j++) begin
      ds[j] = resp(j, 1);
      ab[j] = resp(j, 5);
      bk[j] = resp(j, 6);
      ir |= resp(j, 2);
      ax |= resp(j, 3);
      hl |= resp(j, 4);
    end
    @(negedge clk);
    tick = 1'b0;
    chk("irq", ir, irq);
    chk("enabled", req & ~ds, en);
    chk("brake", 4'(~(req & ~ds) | bk), brk);
    chk("aux", 16'(~(16'(ax) << asel)), aux);
    chk("halt", hl, halt);
    chk("vzero", hl, vz);
    @(negedge clk);
    chk("ramp", ab, rs);
    chk("await", ab, aw);
    rw = '0;
    ack = 1'b1;
    tick = 1'b1;
    repeat (24) @(negedge clk);
    {ack, tick} = 2'b00;
    @(negedge clk);
    chk("cleared", {req, 4'h0, 1'b0}, {en, aw, halt});
  endtask : apply

  initial begin
    logic [2:0] s;
    logic [1:0] a;
    int         b;
    {rst_n, ce, tick, rein, estop, ack, we, slow} = 8'b0100_0000;
    {rw, fq, ma, ms, md, asel} = '0;
    req = '1;
    mdef();
    void'($urandom(32'he0b0));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("reset", {4'h0, 4'hf, 16'hffff}, {en, brk, aux});
    for (int k = 0; k < 15; k++) begin
      fq[k%4][(k == 14) ? 31 : k] = 1'b1;
      apply();
    end
    for (int i = 0; i < 60; i++) begin
      s = 3'($urandom);
      a = (s == 6) ? 2'd0 : 2'($urandom);
      wr(a, s, {16'($urandom), 32'($urandom)});
      req = 4'($urandom);
      asel = 4'($urandom);
      slow = 1'($urandom);
      b = $urandom_range(0, 14);
      fq[2'($urandom)][(b == 14) ? 31 : b] = 1'b1;
      if (i % 3 == 0) fq[2'($urandom)][$urandom_range(0, 13)] = 1'b1;
      apply();
    end
    // a write landing with reinit is dropped
    {ma, ms, md, we, rein} = {2'd0, 3'd1, 48'h0, 2'b11};
    @(negedge clk);
    {we, rein} = 2'b00;
    mdef();
    req = '1;
    fq[0][0] = 1'b1;
    apply();
    // zero global mask on axis 1 must hide its faults everywhere
    wr(2'd1, 3'd0, 48'h0000_0000_0000);
    fq[1][0] = 1'b1;
    apply();
    estop = 1'b1;
    tick = 1'b1;
    @(negedge clk);
    ack = 1'b1;
    @(negedge clk);
    {ack, tick} = 2'b00;
    chk("estop held", 9'h10f, {ea, en, brk});
    estop = 1'b0;
    {ack, tick} = 2'b11;
    repeat (3) @(negedge clk);
    {ack, tick} = 2'b00;
    chk("estop clear", 9'h0f0, {ea, en, brk});
    // enable low freezes everything, even a live estop tick
    {ce, estop, tick} = 3'b011;
    repeat (2) @(negedge clk);
    chk("ce freeze", 9'h0f0, {ea, en, brk});
    {ce, estop, tick} = 3'b100;
    @(negedge clk);
    conclude();
  end

  initial begin
    #200000;
    bad_count++;
    conclude();
  end
endmodule : axis_fault_response_masks_bench
